// *** rtl/uart_status_map.vh ***
`ifndef UART_STATUS_MAP_VH
`define UART_STATUS_MAP_VH

// Register byte offsets, one aligned word each
`define OFS_LINE_STATUS    8'h00
`define OFS_MODEM_STATUS   8'h04
`define OFS_SCRATCH_PAD    8'h08
`define OFS_DIVISOR_LOW    8'h0C
`define OFS_DIVISOR_HIGH   8'h10
`define OFS_DIVISOR_FRAC   8'h14
`define OFS_DEVICE_ID      8'h18
`define OFS_DEVICE_REV     8'h1C
`define OFS_TRIGGER_LEVEL  8'h20
`define OFS_FIFO_COUNT     8'h24

// Line status fields
`define LS_BREAK           4
`define LS_HOLD_EMPTY      5
`define LS_TX_IDLE         6
`define LS_FIFO_ERR        7

// Feature control fields
`define FEAT_SWAP          6
`define FEAT_SEL           7

// Enhanced mode select fields
`define EM_IRQ_IMM         6
`define EM_SAMPLE16        7

// Enhanced feature field
`define EF_ENABLE          4

// Interrupt enable field
`define IE_MODEM           3

// Reset values
`define RST_SCRATCH        8'hFF
`define RST_MODE           8'h80
`define RST_DIVISOR        8'h00
`define RST_TRIGGER        8'h00

`endif

// *** rtl/uart_status_enhanced_regs.v ***
// Overview of operation
// - Break after full low frame, one push
// - No FIFO: empty on transfer, clear on write
// - FIFO mode: empty while transmit FIFO empty
// - Transmitter idle when holding and shift empty
// - FIFO error while any stored byte errored
// - Low modem bits flag input changes
// - Change flag plus enable raises modem interrupt
// - Ring flag only on ring_n rising edge
// - Loopback mirrors modem control into status
// - Scratch pad resets to all ones
// - Swap on: scratch writes go to mode
// - Swap on: scratch reads return FIFO level
// - Mode bits choose level counter source
// - Alternate mode reads receive first, then alternate
// - Four-bit code selects flow hysteresis
// - Error interrupt at holding or at FIFO
// - Sampling bit: 0 eight, 1 sixteen
// - Divisor is integer plus fraction/16
// - Fraction accessible only with enhanced enable
// - Read-only identification and revision bytes
// - Select bit routes trigger and count
// - Enhanced mode bits writable whenever swap is on, enable or not
`timescale 1ns/1ps
`include "uart_status_map.vh"

module uart_status_enhanced_regs #(
	parameter [7:0] DEVICE_ID  = 8'h5C, // Arbitrary value
	parameter [7:0] DEVICE_REV = 8'h03  // Arbitrary value
) (
	// Clock and reset
	input  wire        clk_i,
	input  wire        rst_i,
	// Wishbone slave
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [7:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	// Receive line and timing
	input  wire        rxd_i,
	input  wire        baud_tick_i,
	input  wire [3:0]  frame_bits_i,
	output reg         break_push_o,
	// Transmit path state
	input  wire        fifo_mode_i,
	input  wire        hold_write_i,
	input  wire        hold_to_shift_i,
	input  wire        shift_empty_i,
	input  wire [7:0]  tx_fifo_count_i,
	input  wire [7:0]  rx_fifo_count_i,
	// Receive FIFO error tracking
	input  wire        rx_push_i,
	input  wire        rx_push_err_i,
	input  wire        rx_pop_i,
	input  wire        rx_pop_err_i,
	input  wire        rx_hold_err_i,
	// Modem and control inputs
	input  wire [3:0]  modem_n_i,
	input  wire [3:0]  modem_control_i,
	input  wire        loopback_i,
	input  wire [7:0]  interrupt_enable_i,
	input  wire [7:0]  feature_control_i,
	input  wire [7:0]  enhanced_feature_i,
	// Outputs to the channel
	output wire        modem_irq_o,
	output wire        err_irq_o,
	output reg  [5:0]  hysteresis_o,
	output reg         sample16_o,
	output reg  [19:0] divisor_o,
	output reg  [7:0]  rx_trigger_o,
	output reg  [7:0]  tx_trigger_o
);

////////////////////////////////////////////////////////////////////////////////
// Hysteresis lookup

function [5:0] hyst_lut;
	input [3:0] code;
	begin
		case (code)
			4'h0: hyst_lut = 6'd0;
			4'h1: hyst_lut = 6'd4;
			4'h2: hyst_lut = 6'd6;
			4'h3: hyst_lut = 6'd8;
			4'h4: hyst_lut = 6'd8;
			4'h5: hyst_lut = 6'd16;
			4'h6: hyst_lut = 6'd24;
			4'h7: hyst_lut = 6'd32;
			4'h8: hyst_lut = 6'd40;
			4'h9: hyst_lut = 6'd44;
			4'hA: hyst_lut = 6'd48;
			4'hB: hyst_lut = 6'd52;
			4'hC: hyst_lut = 6'd12;
			4'hD: hyst_lut = 6'd20;
			4'hE: hyst_lut = 6'd28;
			default: hyst_lut = 6'd36;
		endcase
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Bus decode

reg         ack_q;
reg  [7:0]  scratch_q;
reg  [7:0]  mode_q;
reg  [7:0]  div_lo_q;
reg  [7:0]  div_hi_q;
reg  [7:0]  div_frac_q;
reg         alt_tx_q;
reg         break_q;
reg         hold_empty_q;
reg  [8:0]  err_cnt_q;
reg  [3:0]  delta_q;
reg  [3:0]  stat_q;
reg  [3:0]  mod_s1_q;
reg  [3:0]  mod_s2_q;
reg         rx_s1_q;
reg         rx_s2_q;
reg  [3:0]  low_cnt_q;
reg         brk_armed_q;

wire        req     = wb_cyc_i & wb_stb_i & ~ack_q;
wire        wr      = req & wb_we_i & wb_sel_i[0];
wire        rd      = req & ~wb_we_i;
wire [7:0]  wdat    = wb_dat_i[7:0];
wire        swap    = feature_control_i[`FEAT_SWAP];
wire        sel_tx  = feature_control_i[`FEAT_SEL];
wire        enh_en  = enhanced_feature_i[`EF_ENABLE];
wire        div_zero = (div_lo_q == `RST_DIVISOR) && (div_hi_q == `RST_DIVISOR);

wire        rd_ls   = rd && (wb_adr_i == `OFS_LINE_STATUS);
wire        rd_ms   = rd && (wb_adr_i == `OFS_MODEM_STATUS);
wire        rd_sp   = rd && (wb_adr_i == `OFS_SCRATCH_PAD);
wire        wr_sp   = wr && (wb_adr_i == `OFS_SCRATCH_PAD);

always @(posedge clk_i) begin
	if (rst_i) begin
		ack_q <= 1'b0;
	end else begin
		ack_q <= req;
	end
end

always @* begin
	wb_ack_o = ack_q;
end

////////////////////////////////////////////////////////////////////////////////
// Line status

wire        hold_empty = fifo_mode_i ? (tx_fifo_count_i == 8'h00) : hold_empty_q;
wire        tx_idle    = hold_empty & shift_empty_i;
wire        fifo_err   = (err_cnt_q != 9'd0);
wire [7:0]  line_status = {fifo_err, tx_idle, hold_empty, break_q, 4'h0};

always @(posedge clk_i) begin
	if (rst_i) begin
		rx_s1_q <= 1'b1;
		rx_s2_q <= 1'b1;
	end else begin
		rx_s1_q <= rxd_i;
		rx_s2_q <= rx_s1_q;
	end
end

// Break detect: count low bit times, one push per break
always @(posedge clk_i) begin
	if (rst_i) begin
		low_cnt_q    <= 4'h0;
		brk_armed_q  <= 1'b1;
		break_q      <= 1'b0;
		break_push_o <= 1'b0;
	end else begin
		break_push_o <= 1'b0;
		if (rx_s2_q) begin
			low_cnt_q   <= 4'h0;
			brk_armed_q <= 1'b1;
		end else if (baud_tick_i && brk_armed_q) begin
			if (low_cnt_q + 4'h1 >= frame_bits_i) begin
				brk_armed_q  <= 1'b0;
				break_push_o <= 1'b1;
			end else begin
				low_cnt_q <= low_cnt_q + 4'h1;
			end
		end
		if (baud_tick_i && brk_armed_q && !rx_s2_q
			&& (low_cnt_q + 4'h1 >= frame_bits_i)) begin
			break_q <= 1'b1;
		end else if (rd_ls) begin
			break_q <= 1'b0;
		end
	end
end

// Holding register empty without FIFOs, set wins over clear
always @(posedge clk_i) begin
	if (rst_i) begin
		hold_empty_q <= 1'b1;
	end else if (hold_to_shift_i) begin
		hold_empty_q <= 1'b1;
	end else if (hold_write_i) begin
		hold_empty_q <= 1'b0;
	end
end

// Count of errored bytes held in the receive FIFO
always @(posedge clk_i) begin
	if (rst_i) begin
		err_cnt_q <= 9'd0;
	end else begin
		case ({rx_push_i & rx_push_err_i, rx_pop_i & rx_pop_err_i})
			2'b10:   err_cnt_q <= err_cnt_q + 9'd1;
			2'b01:   err_cnt_q <= err_cnt_q - 9'd1;
			default: err_cnt_q <= err_cnt_q;
		endcase
	end
end

assign err_irq_o = mode_q[`EM_IRQ_IMM] ? fifo_err : rx_hold_err_i;

////////////////////////////////////////////////////////////////////////////////
// Modem status

// Status bits: 0 cts, 1 dsr, 2 ri, 3 cd, active high
wire [3:0]  stat_d = loopback_i ?
	{modem_control_i[3], modem_control_i[2], modem_control_i[0], modem_control_i[1]}
	: ~mod_s2_q;
wire [3:0]  change;
assign change[0] = stat_d[0] ^ stat_q[0];
assign change[1] = stat_d[1] ^ stat_q[1];
assign change[2] = stat_q[2] & ~stat_d[2];
assign change[3] = stat_d[3] ^ stat_q[3];
wire [7:0]  modem_status = {stat_q, delta_q};

always @(posedge clk_i) begin
	if (rst_i) begin
		mod_s1_q <= 4'hF;
		mod_s2_q <= 4'hF;
		stat_q   <= 4'h0;
		delta_q  <= 4'h0;
	end else begin
		mod_s1_q <= modem_n_i;
		mod_s2_q <= mod_s1_q;
		stat_q   <= stat_d;
		delta_q  <= (rd_ms ? 4'h0 : delta_q) | change;
	end
end

assign modem_irq_o = (|delta_q) & interrupt_enable_i[`IE_MODEM];

////////////////////////////////////////////////////////////////////////////////
// Scratch, mode select and level readout

wire        alt_mode = (mode_q[1:0] == 2'b11);
reg  [7:0]  fifo_level;

always @* begin
	if (!mode_q[0]) begin
		fifo_level = rx_fifo_count_i;
	end else if (!mode_q[1]) begin
		fifo_level = tx_fifo_count_i;
	end else begin
		fifo_level = alt_tx_q ? tx_fifo_count_i : rx_fifo_count_i;
	end
end

always @(posedge clk_i) begin
	if (rst_i) begin
		scratch_q <= `RST_SCRATCH;
		mode_q    <= `RST_MODE;
		alt_tx_q  <= 1'b0;
	end else begin
		if (wr_sp && swap) begin
			mode_q   <= wdat;
			alt_tx_q <= 1'b0;
		end else if (wr_sp) begin
			scratch_q <= wdat;
		end else if (rd_sp && swap && alt_mode) begin
			alt_tx_q <= ~alt_tx_q;
		end
	end
end

always @* begin
	hysteresis_o = hyst_lut({mode_q[5:4], feature_control_i[1:0]});
	sample16_o   = mode_q[`EM_SAMPLE16];
end

////////////////////////////////////////////////////////////////////////////////
// Divisor and trigger registers

always @(posedge clk_i) begin
	if (rst_i) begin
		div_lo_q     <= `RST_DIVISOR;
		div_hi_q     <= `RST_DIVISOR;
		div_frac_q   <= `RST_DIVISOR;
		rx_trigger_o <= `RST_TRIGGER;
		tx_trigger_o <= `RST_TRIGGER;
	end else if (wr) begin
		case (wb_adr_i)
			`OFS_DIVISOR_LOW:  div_lo_q <= wdat;
			`OFS_DIVISOR_HIGH: div_hi_q <= wdat;
			`OFS_DIVISOR_FRAC: begin
				if (enh_en) begin
					div_frac_q <= wdat;
				end
			end
			`OFS_TRIGGER_LEVEL: begin
				if (sel_tx) begin
					tx_trigger_o <= wdat;
				end else begin
					rx_trigger_o <= wdat;
				end
			end
			default: div_lo_q <= div_lo_q;
		endcase
	end
end

always @(posedge clk_i) begin
	if (rst_i) begin
		divisor_o <= 20'h00000;
	end else begin
		divisor_o <= {div_hi_q, div_lo_q, div_frac_q[3:0]};
	end
end

////////////////////////////////////////////////////////////////////////////////
// Read data

reg  [7:0]  rd_mux;

always @* begin
	case (wb_adr_i)
		`OFS_LINE_STATUS:   rd_mux = line_status;
		`OFS_MODEM_STATUS:  rd_mux = modem_status;
		`OFS_SCRATCH_PAD:   rd_mux = swap ? fifo_level : scratch_q;
		`OFS_DIVISOR_LOW:   rd_mux = div_lo_q;
		`OFS_DIVISOR_HIGH:  rd_mux = div_hi_q;
		`OFS_DIVISOR_FRAC:  rd_mux = enh_en ? div_frac_q : 8'h00;
		`OFS_DEVICE_ID:     rd_mux = div_zero ? DEVICE_ID : 8'h00;
		`OFS_DEVICE_REV:    rd_mux = div_zero ? DEVICE_REV : 8'h00;
		`OFS_FIFO_COUNT:    rd_mux = sel_tx ? tx_fifo_count_i : rx_fifo_count_i;
		default:            rd_mux = 8'h00;
	endcase
end

always @(posedge clk_i) begin
	if (rst_i) begin
		wb_dat_o <= 32'h00000000;
	end else if (rd) begin
		wb_dat_o <= {24'h000000, rd_mux};
	end
end

endmodule

// *** bench/wb_host.sv ***
`timescale 1ns/1ps
module wb_host (
	// Clock
	input  wire        clk_i,
	// Wishbone master
	output reg         wb_cyc_o,
	output reg         wb_stb_o,
	output reg         wb_we_o,
	output reg  [7:0]  wb_adr_o,
	output reg  [3:0]  wb_sel_o,
	output reg  [31:0] wb_dat_o,
	input  wire [31:0] wb_dat_i,
	input  wire        wb_ack_i
);
	initial begin
		{wb_cyc_o, wb_stb_o, wb_we_o, wb_adr_o, wb_sel_o, wb_dat_o} = 47'h0;
	end
	// One classic cycle, held until ack is sampled
	task cycle(input we, input [7:0] a, input [7:0] d, output [31:0] q);
		begin
			@(posedge clk_i);
			{wb_cyc_o, wb_stb_o, wb_we_o, wb_sel_o} <= {2'b11, we, 4'hF};
			wb_adr_o <= a;
			wb_dat_o <= {24'h000000, d};
			@(posedge clk_i);
			while (wb_ack_i !== 1'b1)
				@(posedge clk_i);
			q = wb_dat_i;
			{wb_cyc_o, wb_stb_o} <= 2'b00;
			// Released lines stop showing the last value
			wb_adr_o <= ~a;
			wb_dat_o <= ~wb_dat_o;
		end
	endtask
endmodule

// *** bench/uart_status_enhanced_regs_chk.sv ***
`timescale 1ns/1ps
module uart_status_enhanced_regs_chk #(
	parameter [7:0] DEVICE_ID = 8'h5C
) (
	// Clock and reset
	input wire        clk_i,
	input wire        rst_i,
	// Bus
	input wire        wb_cyc_i,
	input wire        wb_stb_i,
	input wire        wb_we_i,
	input wire [7:0]  wb_adr_i,
	input wire [3:0]  wb_sel_i,
	input wire [31:0] wb_dat_i,
	input wire [31:0] wb_dat_o,
	input wire        wb_ack_o,
	// Channel
	input wire [7:0]  tx_fifo_count_i,
	input wire [7:0]  rx_fifo_count_i,
	input wire [7:0]  interrupt_enable_i,
	input wire [7:0]  feature_control_i,
	input wire [7:0]  enhanced_feature_i,
	input wire        break_push_o,
	input wire        modem_irq_o,
	input wire        sample16_o,
	input wire [19:0] divisor_o
);
	wire take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire rd   = take & ~wb_we_i;
	wire wr   = take & wb_we_i & wb_sel_i[0];
	wire mwr  = wr & (wb_adr_i == 8'h08) & feature_control_i[6];
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	////////////////////////////////
	property p_irq; !interrupt_enable_i[3] |-> !modem_irq_o; endproperty
	a_irq: assert property (p_irq) else $error("modem irq while off");
	property p_brk; break_push_o |=> !break_push_o [*2]; endproperty
	a_brk: assert property (p_brk) else $error("break pushed twice");
	property p_frac; !enhanced_feature_i[4] |=> $stable(divisor_o[3:0]); endproperty
	a_frac: assert property (p_frac) else $error("fraction changed");
	property p_id;
		rd && wb_adr_i == 8'h18 && divisor_o[19:4] == 16'h0000 |=> wb_dat_o[7:0] == DEVICE_ID;
	endproperty
	a_id: assert property (p_id) else $error("bad identifier");
	property p_cnt;
		rd && wb_adr_i == 8'h24 |=> wb_dat_o[7:0] ==
			($past(feature_control_i[7]) ? $past(tx_fifo_count_i) : $past(rx_fifo_count_i));
	endproperty
	a_cnt: assert property (p_cnt) else $error("bad level count");
	property p_div;
		wr && wb_adr_i == 8'h0C |=> ##1 divisor_o[11:4] == $past(wb_dat_i[7:0], 2);
	endproperty
	a_div: assert property (p_div) else $error("bad divisor");
	property p_smp; $changed(sample16_o) |-> $past(mwr) || $past(rst_i); endproperty
	a_smp: assert property (p_smp) else $error("sampling changed");
	property p_swp; wr && wb_adr_i == 8'h08 && !feature_control_i[6] |=> $stable(sample16_o);
	endproperty
	a_swp: assert property (p_swp) else $error("mode hit unswapped");
	c_id: cover property (rd && wb_adr_i == 8'h18);
	c_irq: cover property (modem_irq_o);
	c_brk: cover property (break_push_o);
endmodule
bind uart_status_enhanced_regs uart_status_enhanced_regs_chk #(.DEVICE_ID(DEVICE_ID)) i_chk (
	.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
	.wb_ack_o, .tx_fifo_count_i, .rx_fifo_count_i, .interrupt_enable_i, .feature_control_i,
	.enhanced_feature_i, .break_push_o, .modem_irq_o, .sample16_o, .divisor_o
);

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked = samples_checked + 1; if ((a) !== (b)) begin \
	failures = failures + 1; $display("[ERR] %0t got %h want %h", $time, a, b); end end
module tb_top;
	localparam [7:0] ID  = 8'hA7; // Arbitrary value
	localparam [7:0] REV = 8'h2B; // Arbitrary value
	reg         clk_i, rst_i, rxd_i, baud_tick_i, fifo_mode_i, hold_write_i, hold_to_shift_i;
	reg         shift_empty_i, rx_push_i, rx_push_err_i, rx_pop_i, rx_pop_err_i, rx_hold_err_i;
	reg         loopback_i;
	reg  [3:0]  frame_bits_i, modem_n_i, modem_control_i;
	reg  [7:0]  tx_fifo_count_i, rx_fifo_count_i, interrupt_enable_i, feature_control_i;
	reg  [7:0]  enhanced_feature_i;
	wire        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, break_push_o, modem_irq_o, err_irq_o;
	wire        sample16_o;
	wire [3:0]  wb_sel_i;
	wire [5:0]  hysteresis_o;
	wire [7:0]  wb_adr_i, rx_trigger_o, tx_trigger_o;
	wire [19:0] divisor_o;
	wire [31:0] wb_dat_i, wb_dat_o;
	reg  [31:0] q;
	integer     failures, samples_checked, pushes;
	uart_status_enhanced_regs #(.DEVICE_ID(ID), .DEVICE_REV(REV)) i_uart_status_enhanced_regs (
		.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
		.wb_dat_o, .wb_ack_o, .rxd_i, .baud_tick_i, .frame_bits_i, .break_push_o, .fifo_mode_i,
		.hold_write_i, .hold_to_shift_i, .shift_empty_i, .tx_fifo_count_i, .rx_fifo_count_i,
		.rx_push_i, .rx_push_err_i, .rx_pop_i, .rx_pop_err_i, .rx_hold_err_i, .modem_n_i,
		.modem_control_i, .loopback_i, .interrupt_enable_i, .feature_control_i,
		.enhanced_feature_i, .modem_irq_o, .err_irq_o, .hysteresis_o, .sample16_o, .divisor_o,
		.rx_trigger_o, .tx_trigger_o);
	wb_host i_wb_host (.clk_i, .wb_cyc_o(wb_cyc_i), .wb_stb_o(wb_stb_i), .wb_we_o(wb_we_i),
		.wb_adr_o(wb_adr_i), .wb_sel_o(wb_sel_i), .wb_dat_o(wb_dat_i), .wb_dat_i(wb_dat_o),
		.wb_ack_i(wb_ack_o));
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) if (break_push_o === 1'b1) pushes <= pushes + 1;
	////////////////////////////////
	task wr(input [7:0] a, input [7:0] d);
		i_wb_host.cycle(1'b1, a, d, q);
	endtask
	task rdchk(input [7:0] a, input [7:0] e);
		begin
			i_wb_host.cycle(1'b0, a, 8'h00, q);
			`CHK(q, {24'h000000, e})
		end
	endtask
	task give_verdict;
		begin
			$display("checks %0d errors %0d", samples_checked, failures);
			if (failures == 0 && samples_checked > 0)
				$display("bench passed");
			else
				$display("bench failed");
			$finish;
		end
	endtask
	////////////////////////////////
	task t_line;
		begin
			rdchk(8'h00, 8'h60);
			@(posedge clk_i) hold_write_i <= 1'b1;
			@(posedge clk_i) hold_write_i <= 1'b0;
			rdchk(8'h00, 8'h00);
			@(posedge clk_i) hold_to_shift_i <= 1'b1;
			shift_empty_i <= 1'b0;
			@(posedge clk_i) hold_to_shift_i <= 1'b0;
			rdchk(8'h00, 8'h20);
			@(posedge clk_i) shift_empty_i <= 1'b1;
			fifo_mode_i <= 1'b1;
			tx_fifo_count_i <= 8'h01;
			rdchk(8'h00, 8'h00);
			@(posedge clk_i) tx_fifo_count_i <= 8'h00;
			rdchk(8'h00, 8'h60);
			@(posedge clk_i) {rx_push_i, rx_push_err_i} <= 2'b11;
			@(posedge clk_i) rx_push_i <= 1'b0;
			rdchk(8'h00, 8'hE0);
			@(posedge clk_i) {rx_pop_i, rx_pop_err_i} <= 2'b11;
			@(posedge clk_i) rx_pop_i <= 1'b0;
			rdchk(8'h00, 8'h60);
			@(posedge clk_i) rxd_i <= 1'b0;
			repeat (3) @(posedge clk_i);
			repeat (12) begin
				@(posedge clk_i) baud_tick_i <= 1'b1;
				@(posedge clk_i) baud_tick_i <= 1'b0;
			end
			`CHK(pushes, 1)
			rdchk(8'h00, 8'h70);
			rxd_i <= 1'b1;
			rdchk(8'h00, 8'h60);
		end
	endtask
	task t_swap;
		begin
			rdchk(8'h08, 8'hFF);
			`CHK(sample16_o, 1'b1)
			wr(8'h08, 8'h5A);
			@(posedge clk_i) feature_control_i <= 8'h43;
			{rx_fifo_count_i, tx_fifo_count_i} <= 16'h1122;
			wr(8'h08, 8'h23);
			`CHK(hysteresis_o, 6'd52)
			`CHK(sample16_o, 1'b0)
			rdchk(8'h08, 8'h11);
			rdchk(8'h08, 8'h22);
			rdchk(8'h08, 8'h11);
			wr(8'h08, 8'hB1);
			`CHK(hysteresis_o, 6'd36)
			rdchk(8'h08, 8'h22);
			wr(8'h08, 8'h12);
			rdchk(8'h08, 8'h11);
			@(posedge clk_i) rx_hold_err_i <= 1'b1;
			@(posedge clk_i);
			`CHK(err_irq_o, 1'b1)
			wr(8'h08, 8'h40);
			`CHK(err_irq_o, 1'b0)
			@(posedge clk_i) feature_control_i <= 8'h80;
			wr(8'h20, 8'h30);
			rdchk(8'h24, 8'h22);
			@(posedge clk_i) feature_control_i <= 8'h00;
			wr(8'h20, 8'h10);
			rdchk(8'h24, 8'h11);
			`CHK({tx_trigger_o, rx_trigger_o}, 16'h3010)
			rdchk(8'h08, 8'h5A);
		end
	endtask
	task t_modem;
		begin
			@(posedge clk_i) modem_n_i <= 4'b1110;
			repeat (4) @(posedge clk_i);
			`CHK(modem_irq_o, 1'b1)
			rdchk(8'h04, 8'h11);
			rdchk(8'h04, 8'h10);
			@(posedge clk_i) modem_n_i <= 4'b1010;
			repeat (4) @(posedge clk_i);
			rdchk(8'h04, 8'h50);
			@(posedge clk_i) modem_n_i <= 4'b1110;
			repeat (4) @(posedge clk_i);
			rdchk(8'h04, 8'h14);
			@(posedge clk_i) {loopback_i, modem_control_i} <= 5'b10110;
			repeat (4) @(posedge clk_i);
			rdchk(8'h04, 8'h50);
			@(posedge clk_i) modem_control_i <= 4'b1001;
			repeat (4) @(posedge clk_i);
			rdchk(8'h04, 8'hAF);
		end
	endtask
	task t_div;
		begin
			wr(8'h14, 8'h07);
			rdchk(8'h14, 8'h00);
			rdchk(8'h18, ID);
			wr(8'h0C, 8'h34);
			wr(8'h10, 8'h12);
			rdchk(8'h18, 8'h00);
			@(posedge clk_i) enhanced_feature_i <= 8'h10;
			wr(8'h14, 8'h09);
			rdchk(8'h14, 8'h09);
			`CHK(divisor_o, 20'h12349)
			@(posedge clk_i) enhanced_feature_i <= 8'h00;
			wr(8'h14, 8'h05);
			`CHK(divisor_o, 20'h12349)
			wr(8'h0C, 8'h00);
			wr(8'h10, 8'h00);
			rdchk(8'h1C, REV);
		end
	endtask
	////////////////////////////////
	initial begin
		{rst_i, rxd_i, shift_empty_i, interrupt_enable_i, modem_n_i, frame_bits_i} = 19'h708FA;
		{baud_tick_i, fifo_mode_i, hold_write_i, hold_to_shift_i, loopback_i, rx_hold_err_i} = 6'h0;
		{rx_push_i, rx_push_err_i, rx_pop_i, rx_pop_err_i, modem_control_i} = 8'h0;
		{tx_fifo_count_i, rx_fifo_count_i, feature_control_i, enhanced_feature_i} = 32'h0;
		{failures, samples_checked, pushes} = 96'h0;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		t_swap;
		t_line;
		t_modem;
		t_div;
		give_verdict;
	end
	initial begin
		#100000;
		failures = failures + 1;
		give_verdict;
	end
endmodule
